// ### core/brg_clock_gen.sv
// Bit-rate clock generation for two serial channels
`timescale 1ns/1ns

// ==========================================================
// Two-flop synchroniser with rising-edge pulse
// Pin levels move off the clock, so two flops let them settle
module brg_sync_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous pin and results
  input wire logic pin,
  output logic level,
  output logic rise
);
  // Metastable stage and edge history
  logic meta;
  logic last;

  // First flop feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      level <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin;
      level <= meta;
      last <= level;
    end
  end

  // History starts low like an idle pin, so reset raises no false edge
  assign rise = level & ~last;
endmodule

// ==========================================================
// One channel: divider, oversampler, internal timing, command timing
module brg_channel
  import brg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Shared oscillator, synchronised
  input wire logic osc_level,
  input wire logic osc_rise,
  // External transmit clock, synchronised
  input wire logic tx_ext_rise,
  // Configuration
  input wire logic [BRG_REG_W-1:0] cfg_first,
  input wire logic [BRG_REG_W-1:0] cfg_second,
  input wire logic [BRG_REG_W-1:0] cfg_fourth,
  input wire logic [BRG_REG_W-1:0] divisor_low,
  input wire logic master_mode,
  input wire logic tx_external,
  // Command write
  input wire logic cmd_write,
  input wire logic [BRG_REG_W-1:0] cmd_data,
  // Results
  output logic div_clock,
  output logic bit_tick,
  output logic internal_tick,
  output logic cmd_busy,
  output logic cmd_exec,
  output logic [BRG_REG_W-1:0] cmd_code,
  output logic cmd_lost
);
  // Decoded configuration fields
  logic oversample;
  logic div_enable;
  logic enhanced;
  logic [BRG_VALUE_W-1:0] value;
  logic [BRG_VALUE_W-1:0] value_eff;
  logic [BRG_EXP_W-1:0] exponent;
  logic [BRG_MANT_W-1:0] mantissa;

  // Divider counter and its output
  logic [BRG_CNT_W-1:0] reload;
  logic [BRG_CNT_W-1:0] count;
  logic toggle_clk;
  logic div_tick;

  // Oversampler, quarter divider and command sequencer
  logic [3:0] over_count;
  logic [1:0] quarter_count;
  logic quarter_tick;
  brg_cmd_state_t cmd_state;
  logic [1:0] cmd_count;

  // Field extraction
  assign oversample = cfg_first[BRG_OVERSAMPLE_BIT];
  assign div_enable = cfg_second[BRG_DIV_ENABLE_BIT];
  assign enhanced = cfg_fourth[BRG_ENH_ENABLE_BIT];
  assign value = {cfg_second[BRG_HIGH_BITS_MSB:BRG_HIGH_BITS_LSB], divisor_low};
  assign exponent = {cfg_second[BRG_HIGH_BITS_MSB:BRG_HIGH_BITS_LSB],
                     divisor_low[BRG_EXP_LSB_MSB:BRG_HIGH_BITS_LSB]};
  assign mantissa = divisor_low[BRG_MANT_MSB:0];

  // Zero low field forces the whole value to zero
  // Kept on purpose: existing host software expects this quirk
  assign value_eff = (value[BRG_MANT_W-1:0] == BRG_MANT_ZERO) ? '0 : value;

  // Ticks per half period (or full period when enhanced and exponent is zero), minus one
  // Enhanced m>0 reloads (n+1)*2^(m-1), so two halves give (n+1)*2^m
  // Widest case is 64 shifted by 14, well inside the counter width
  always_comb begin
    reload = '0;
    if (enhanced) begin
      if (exponent == BRG_EXP_ZERO) begin
        reload = BRG_CNT_W'(mantissa);
      end else begin
        reload = BRG_CNT_W'((BRG_CNT_W'(mantissa) + BRG_CNT_ONE)
                 << (exponent - 4'h1)) - BRG_CNT_ONE;
      end
    end else begin
      reload = BRG_CNT_W'(value_eff);
    end
  end

  // Reloading counter; a new setting takes effect at the next reload, no stall
  // Limitation: a change waits for the running count to expire
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      toggle_clk <= 1'b0;
    end else if (osc_rise) begin
      if (count == '0) begin
        count <= reload;
        if (enhanced && exponent == BRG_EXP_ZERO) begin
          toggle_clk <= 1'b1;
        end else begin
          toggle_clk <= ~toggle_clk;
        end
      end else begin
        count <= count - BRG_CNT_ONE;
        if (enhanced && exponent == BRG_EXP_ZERO) begin
          toggle_clk <= 1'b0;
        end
      end
    end
  end

  // Divided clock; divider off passes the oscillator (divisor one)
  // Registered, so it lags the counter by one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_clock <= 1'b0;
    end else begin
      div_clock <= div_enable ? toggle_clk : osc_level;
    end
  end

  // One pulse per divisor period, at the rising edge of the divided clock
  // Taken at the reload that raises the output, so no extra flop is needed
  assign div_tick = div_enable
                  ? (osc_rise && count == '0 && (~toggle_clk ||
                     (enhanced && exponent == BRG_EXP_ZERO)))
                  : osc_rise;

  // Oversampling by sixteen
  // Cleared while off, so enabling starts counting a fresh bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      over_count <= '0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (!oversample) begin
        over_count <= '0;
        bit_tick <= div_tick;
      end else if (div_tick) begin
        over_count <= over_count + 4'h1;
        bit_tick <= (over_count == BRG_OVERSAMPLE_LAST);
      end
    end
  end

  // Master clock quarter divider
  // Free-running; its phase against a command is arbitrary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quarter_count <= '0;
    end else if (osc_rise) begin
      quarter_count <= quarter_count + 2'h1;
    end
  end

  assign quarter_tick = osc_rise && (quarter_count == BRG_QUARTER_LAST);

  // Internal timing source: master clock, or the selected transmit clock
  // Hazard: a stopped transmit clock stalls commands until it runs again
  always_comb begin
    if (master_mode) begin
      internal_tick = cfg_fourth[BRG_QUARTER_BIT] ? quarter_tick : osc_rise;
    end else begin
      internal_tick = tx_external ? tx_ext_rise : bit_tick;
    end
  end

  // Command sequencer; a slow internal clock stretches the busy time
  // A write while busy is dropped and flagged, never queued
  // Busy falls as execute rises, so the next write may follow at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_state <= BRG_CMD_IDLE;
      cmd_count <= '0;
      cmd_code <= '0;
      cmd_exec <= 1'b0;
      cmd_lost <= 1'b0;
    end else begin
      cmd_exec <= 1'b0;
      cmd_lost <= 1'b0;
      case (cmd_state)
        BRG_CMD_IDLE: begin
          if (cmd_write) begin
            cmd_code <= cmd_data;
            cmd_count <= '0;
            cmd_state <= BRG_CMD_BUSY;
          end
        end
        BRG_CMD_BUSY: begin
          if (cmd_write) begin
            cmd_lost <= 1'b1;
          end
          if (internal_tick) begin
            if (cmd_count == BRG_CMD_TICKS - 2'h1) begin
              cmd_exec <= 1'b1;
              cmd_state <= BRG_CMD_IDLE;
            end else begin
              cmd_count <= cmd_count + 2'h1;
            end
          end
        end
        default: begin
          cmd_state <= BRG_CMD_IDLE;
        end
      endcase
    end
  end

  assign cmd_busy = (cmd_state == BRG_CMD_BUSY);
endmodule

// ==========================================================
// Top: shared oscillator, two channels, general port pins
module brg_clock_gen
  import brg_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Shared oscillator from the programmable generator
  input wire logic OSCILLATOR_INPUT,
  // Per-channel external transmit clock pins
  input wire logic [BRG_CHANNELS-1:0] TX_CLOCK_PIN,
  // Per-channel configuration
  input wire logic [BRG_CHANNELS-1:0][BRG_REG_W-1:0] CHANNEL_CONFIG_FIRST,
  input wire logic [BRG_CHANNELS-1:0][BRG_REG_W-1:0] CHANNEL_CONFIG_SECOND,
  input wire logic [BRG_CHANNELS-1:0][BRG_REG_W-1:0] CHANNEL_CONFIG_FOURTH,
  input wire logic [BRG_CHANNELS-1:0][BRG_REG_W-1:0] BAUD_DIVISOR_LOW,
  input wire logic [BRG_CHANNELS-1:0] MASTER_CLOCK_ENABLE,
  input wire logic [BRG_CHANNELS-1:0] TX_CLOCK_EXTERNAL,
  // Per-channel command register writes
  input wire logic [BRG_CHANNELS-1:0] COMMAND_WRITE,
  input wire logic [BRG_CHANNELS-1:0][BRG_REG_W-1:0] COMMAND_REGISTER,
  // General port register and direction
  input wire logic GENERAL_PORT_WRITE,
  input wire logic [BRG_REG_W-1:0] GENERAL_PORT_REGISTER,
  input wire logic [BRG_REG_W-1:0] GENERAL_PORT_DIRECTION,
  // Clock results
  output logic [BRG_CHANNELS-1:0] DIVIDED_CLOCK,
  output logic [BRG_CHANNELS-1:0] BIT_TICK,
  output logic [BRG_CHANNELS-1:0] INTERNAL_TICK,
  // Command status
  output logic [BRG_CHANNELS-1:0] COMMAND_BUSY,
  output logic [BRG_CHANNELS-1:0] COMMAND_EXECUTE,
  output logic [BRG_CHANNELS-1:0][BRG_REG_W-1:0] COMMAND_CODE,
  output logic [BRG_CHANNELS-1:0] COMMAND_LOST,
  // General port pins
  output logic [BRG_REG_W-1:0] GENERAL_PORT_OUT,
  output logic [BRG_REG_W-1:0] GENERAL_PORT_OE
);
  // Synchronised oscillator and transmit edges
  logic osc_level;
  logic osc_rise;
  logic [BRG_CHANNELS-1:0] tx_rise;

  // One synchroniser for the oscillator, shared by both channels
  // Both channels see one edge, so a rate change moves them together
  brg_sync_edge u_osc_sync (
    .clk(CLOCK),
    .rst(RST),
    .pin(OSCILLATOR_INPUT),
    .level(osc_level),
    .rise(osc_rise)
  );

  // Channels and their transmit clock pins
  // Only the rising edge of a transmit pin is used; its level is left open
  for (genvar ch = 0; ch < BRG_CHANNELS; ch++) begin : g_ch
    brg_sync_edge u_tx_sync (
      .clk(CLOCK),
      .rst(RST),
      .pin(TX_CLOCK_PIN[ch]),
      .level(),
      .rise(tx_rise[ch])
    );

    brg_channel u_channel (
      .clk(CLOCK),
      .rst(RST),
      .osc_level(osc_level),
      .osc_rise(osc_rise),
      .tx_ext_rise(tx_rise[ch]),
      .cfg_first(CHANNEL_CONFIG_FIRST[ch]),
      .cfg_second(CHANNEL_CONFIG_SECOND[ch]),
      .cfg_fourth(CHANNEL_CONFIG_FOURTH[ch]),
      .divisor_low(BAUD_DIVISOR_LOW[ch]),
      .master_mode(MASTER_CLOCK_ENABLE[ch]),
      .tx_external(TX_CLOCK_EXTERNAL[ch]),
      .cmd_write(COMMAND_WRITE[ch]),
      .cmd_data(COMMAND_REGISTER[ch]),
      .div_clock(DIVIDED_CLOCK[ch]),
      .bit_tick(BIT_TICK[ch]),
      .internal_tick(INTERNAL_TICK[ch]),
      .cmd_busy(COMMAND_BUSY[ch]),
      .cmd_exec(COMMAND_EXECUTE[ch]),
      .cmd_code(COMMAND_CODE[ch]),
      .cmd_lost(COMMAND_LOST[ch])
    );
  end

  // Port register; generator data and clock bits always drive
  // Direction only matters for the other bits; the host cannot float these
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      GENERAL_PORT_OUT <= BRG_PORT_RESET;
      GENERAL_PORT_OE <= BRG_PORT_GEN_MASK;
    end else begin
      if (GENERAL_PORT_WRITE) begin
        GENERAL_PORT_OUT <= GENERAL_PORT_REGISTER;
      end
      GENERAL_PORT_OE <= GENERAL_PORT_DIRECTION | BRG_PORT_GEN_MASK;
    end
  end
endmodule

// ### core/brg_pkg.sv
// Constants, field positions and types of the bit-rate clock generator
package brg_pkg;
  // Channel count and register width
  localparam int BRG_CHANNELS = 2;
  localparam int BRG_REG_W = 8;
  // Field positions
  localparam int BRG_OVERSAMPLE_BIT = 3;
  localparam int BRG_DIV_ENABLE_BIT = 5;
  localparam int BRG_ENH_ENABLE_BIT = 6;
  localparam int BRG_QUARTER_BIT = 7;
  localparam int BRG_HIGH_BITS_MSB = 7;
  localparam int BRG_HIGH_BITS_LSB = 6;
  localparam int BRG_MANT_MSB = 5;
  localparam int BRG_EXP_LSB_MSB = 7;
  // Divider widths
  localparam int BRG_VALUE_W = 10;
  localparam int BRG_MANT_W = 6;
  localparam int BRG_EXP_W = 4;
  localparam int BRG_CNT_W = 22;
  localparam logic [BRG_MANT_W-1:0] BRG_MANT_ZERO = 6'h00;
  localparam logic [BRG_EXP_W-1:0] BRG_EXP_ZERO = 4'h0;
  localparam logic [BRG_CNT_W-1:0] BRG_CNT_ONE = 22'h000001;
  // Oversampling ratio, counted as 0..15
  localparam logic [3:0] BRG_OVERSAMPLE_LAST = 4'hf;
  // Master clock quarter divide, counted as 0..3
  localparam logic [1:0] BRG_QUARTER_LAST = 2'h3;
  // Command execution: 2.5 internal clocks, finished by the second rising edge
  localparam logic [1:0] BRG_CMD_TICKS = 2'h2;
  // Reference of the external generator, in kHz (informational)
  localparam real BRG_REFERENCE_KHZ = 18432.0;
  // Port register reset and generator programming pins
  localparam logic [BRG_REG_W-1:0] BRG_PORT_RESET = 8'h00;
  localparam int BRG_PORT_GEN_DATA = 0;
  localparam int BRG_PORT_GEN_CLOCK = 1;
  localparam logic [BRG_REG_W-1:0] BRG_PORT_GEN_MASK = 8'h03;
  // Command sequencer states
  typedef enum logic [0:0] {
    BRG_CMD_IDLE = 1'b0,
    BRG_CMD_BUSY = 1'b1
  } brg_cmd_state_t;
endpackage

// ### dv/brg_osc_model.sv
// Behavioural model of the programmable clock generator on the oscillator pin
`timescale 1ns/1ns

// ==========================================================
// Generator: free-running output, serially loaded half period
module brg_osc_model (
  // Programming pins from the general port
  input wire logic prog_data,
  input wire logic prog_clock,
  // Generated clock
  output logic osc
);
  // Half period in ns; a fixed reference sets the rate in the real part
  int half = 20;
  logic [7:0] shift = 8'h00;
  int nbits = 0;
  // Never stops, so a new rate takes over mid-run
  initial begin
    osc = 1'b0;
    #3;
    forever #(half) osc = ~osc;
  end
  // Data is sampled on the programming clock rise
  always @(posedge prog_clock) begin
    shift = {shift[6:0], prog_data};
    nbits = nbits + 1;
    if (nbits == 8) begin
      half = int'(shift);
      nbits = 0;
    end
  end
endmodule

// ### dv/brg_clock_gen_chk.sv
// Port assertions for the bit-rate clock generator
`timescale 1ns/1ns

// ==========================================================
// Checker: command timing on channel 0 and the port pins
module brg_clock_gen_chk (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Command and timing
  input wire logic [1:0] COMMAND_WRITE,
  input wire logic [1:0][7:0] COMMAND_REGISTER,
  input wire logic [1:0] COMMAND_BUSY,
  input wire logic [1:0] COMMAND_EXECUTE,
  input wire logic [1:0][7:0] COMMAND_CODE,
  input wire logic [1:0] COMMAND_LOST,
  input wire logic [1:0] INTERNAL_TICK,
  input wire logic [1:0] BIT_TICK,
  // General port
  input wire logic GENERAL_PORT_WRITE,
  input wire logic [7:0] GENERAL_PORT_REGISTER,
  input wire logic [7:0] GENERAL_PORT_DIRECTION,
  input wire logic [7:0] GENERAL_PORT_OUT,
  input wire logic [7:0] GENERAL_PORT_OE
);
  logic [1:0] tick_cnt;
  // Ticks seen while busy; saturates so a stuck command cannot wrap
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tick_cnt <= 2'h0;
    end else if (COMMAND_WRITE[0] && !COMMAND_BUSY[0]) begin
      tick_cnt <= 2'h0;
    end else if (COMMAND_BUSY[0] && INTERNAL_TICK[0] && tick_cnt != 2'h3) begin
      tick_cnt <= tick_cnt + 2'h1;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_accept;
    COMMAND_WRITE[0] && !COMMAND_BUSY[0];
  endsequence
  sequence s_refused;
    COMMAND_WRITE[0] && COMMAND_BUSY[0];
  endsequence
  a_cmd_accept: assert property (s_accept |=> COMMAND_BUSY[0] &&
    COMMAND_CODE[0] == $past(COMMAND_REGISTER[0])) else $error("command not taken");
  a_cmd_lost: assert property (s_refused |=> COMMAND_LOST[0] &&
    $stable(COMMAND_CODE[0])) else $error("refused command not flagged");
  a_lost_cause: assert property (COMMAND_LOST[0] |-> $past(COMMAND_WRITE[0] &&
    COMMAND_BUSY[0])) else $error("spurious lost flag");
  a_exec_clears: assert property (COMMAND_EXECUTE[0] |-> !COMMAND_BUSY[0] &&
    $past(COMMAND_BUSY[0])) else $error("execute without busy");
  a_exec_ticks: assert property (COMMAND_EXECUTE[0] |-> tick_cnt == 2'h2)
    else $error("execute at wrong tick count");
  a_exec_timely: assert property (COMMAND_BUSY[0] && INTERNAL_TICK[0] &&
    tick_cnt == 2'h1 |=> COMMAND_EXECUTE[0]) else $error("execute late");
  a_tick_single: assert property (BIT_TICK[0] |=> !BIT_TICK[0])
    else $error("bit tick too long");
  a_prog_pins_out: assert property (GENERAL_PORT_OE[1:0] == 2'b11)
    else $error("programming pins not outputs");
  a_port_update: assert property (GENERAL_PORT_WRITE |=>
    GENERAL_PORT_OUT == $past(GENERAL_PORT_REGISTER) &&
    GENERAL_PORT_OE == ($past(GENERAL_PORT_DIRECTION) | 8'h03)) else $error("port update");
endmodule

bind brg_clock_gen brg_clock_gen_chk chk (.CLOCK(CLOCK), .RST(RST),
  .COMMAND_WRITE(COMMAND_WRITE), .COMMAND_REGISTER(COMMAND_REGISTER),
  .COMMAND_BUSY(COMMAND_BUSY), .COMMAND_EXECUTE(COMMAND_EXECUTE),
  .COMMAND_CODE(COMMAND_CODE), .COMMAND_LOST(COMMAND_LOST),
  .INTERNAL_TICK(INTERNAL_TICK), .BIT_TICK(BIT_TICK),
  .GENERAL_PORT_WRITE(GENERAL_PORT_WRITE), .GENERAL_PORT_REGISTER(GENERAL_PORT_REGISTER),
  .GENERAL_PORT_DIRECTION(GENERAL_PORT_DIRECTION), .GENERAL_PORT_OUT(GENERAL_PORT_OUT),
  .GENERAL_PORT_OE(GENERAL_PORT_OE));

// ### dv/brg_clock_gen_tb.sv
// Self-checking testbench for the bit-rate clock generator
`timescale 1ns/1ns

// ==========================================================
// Bench top
module brg_clock_gen_tb
  import brg_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, osc, port_wr_en = 1'b0;
  logic [1:0] tx_pin = 2'b00, master = 2'b00, tx_ext = 2'b00, cmd_wr = 2'b00;
  logic [1:0] busy, execu, lost, div_clk, bit_tick, int_tick;
  logic [1:0][7:0] cfg1 = '0, cfg2 = '0, cfg4 = '0, low = '0, cmd_reg = '0, cmd_code;
  logic [7:0] port_reg = 8'h00, port_dir = 8'h00, port_out, port_oe, c2, lo, c4;
  logic [31:0] seed = 32'hef944c43, r;
  logic [31:0] tab [0:4] = '{32'h00550001, 32'he0400000, 32'h20bf0000, 32'h20054001,
    32'h60004000};
  int n_mismatch = 0, checks_done = 0, per = 4, ch = 0, i, n, d, q;
  logic ov;
  brg_clock_gen dut (.CLOCK(clock), .RST(rst), .OSCILLATOR_INPUT(osc), .TX_CLOCK_PIN(tx_pin),
    .CHANNEL_CONFIG_FIRST(cfg1), .CHANNEL_CONFIG_SECOND(cfg2), .CHANNEL_CONFIG_FOURTH(cfg4),
    .BAUD_DIVISOR_LOW(low), .MASTER_CLOCK_ENABLE(master), .TX_CLOCK_EXTERNAL(tx_ext),
    .COMMAND_WRITE(cmd_wr), .COMMAND_REGISTER(cmd_reg), .GENERAL_PORT_WRITE(port_wr_en),
    .GENERAL_PORT_REGISTER(port_reg), .GENERAL_PORT_DIRECTION(port_dir),
    .DIVIDED_CLOCK(div_clk), .BIT_TICK(bit_tick), .INTERNAL_TICK(int_tick),
    .COMMAND_BUSY(busy), .COMMAND_EXECUTE(execu), .COMMAND_CODE(cmd_code),
    .COMMAND_LOST(lost), .GENERAL_PORT_OUT(port_out), .GENERAL_PORT_OE(port_oe));
  brg_osc_model gen (.prog_data(port_out[0]), .prog_clock(port_out[1]), .osc(osc));
  // Free-running 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Divisor from the configuration fields
  function int exp_div(logic [7:0] s2, logic [7:0] sl, logic [7:0] s4);
    logic [9:0] v;
    v = {s2[7:6], sl};
    if (!s2[5]) return 1;
    if (s4[6]) return (int'(sl[5:0]) + 1) << {s2[7:6], sl[7:6]};
    if (v[5:0] == 6'h00) v = 10'h000;
    return 2 * (int'(v) + 1);
  endfunction
  function logic pick(int w);
    case (w)
      1: return bit_tick[ch];
      2: return int_tick[ch];
      default: return div_clk[ch];
    endcase
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cycles from one rise to the next rise (w 3: to the fall), bounded
  task gap(input int w, output int m);
    int k, t0;
    logic prev, cur;
    m = 0;
    t0 = -1;
    prev = pick(w);
    for (k = 0; k < 20000 && m == 0; k++) begin
      @(negedge clock);
      cur = pick(w);
      if (t0 >= 0 && (w == 3 ? (prev && !cur) : (cur && !prev))) m = k - t0;
      else if (t0 < 0 && cur && !prev) t0 = k;
      prev = cur;
    end
    if (m == 0) begin
      n_mismatch++;
      results();
    end
  endtask
  task wait_exec(output int m);
    for (m = 0; m < 200 && execu[ch] !== 1'b1; m++) @(negedge clock);
    check(execu[ch], 1'b1);
    if (m == 200) results();
  endtask
  task port_wr(input logic [7:0] v);
    logic [7:0] dv;
    dv = 8'(rnd());
    @(posedge clock);
    port_wr_en <= 1'b1;
    port_reg <= v;
    port_dir <= dv;
    @(posedge clock);
    port_wr_en <= 1'b0;
    @(negedge clock);
    check(port_out, v);
    check(port_oe, dv | 8'h03);
  endtask
  task prog_gen(input logic [7:0] w);
    int k;
    for (k = 7; k >= 0; k--) begin
      port_wr({7'h00, w[k]});
      port_wr({7'h01, w[k]});
    end
  endtask
  // Same divisor on both channels, both follow the shared oscillator
  task both();
    @(posedge clock);
    cfg1 <= '0;
    cfg4 <= '0;
    cfg2 <= {8'h20, 8'h20};
    low <= {8'h03, 8'h03};
    for (ch = 0; ch < 2; ch++) begin
      gap(0, n);
      gap(0, n);
      check(n, per * 8);
    end
    $display("shared oscillator test done, period %0d", per);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 12; i++) begin
      r = rnd();
      ch = int'(r[8]);
      {c2, lo, c4} = tab[i % 5][31:8];
      ov = tab[i % 5][0];
      if (i >= 5) begin
        c2 = {3'b001, r[4:0]};
        lo = r[0] ? r[23:16] : {1'b0, r[22:16]};
        c4 = {1'b0, r[0], r[29:24]};
        ov = r[1] && exp_div(c2, lo, c4) <= 64;
      end
      d = exp_div(c2, lo, c4);
      @(posedge clock);
      cfg1[ch] <= {r[31:28], ov, r[26:24]};
      cfg2[ch] <= c2;
      low[ch] <= lo;
      cfg4[ch] <= c4;
      gap(0, n);
      gap(0, n);
      check(n, per * d);
      gap(3, n);
      check(n, (c2[5] && c4[6] && {c2[7:6], lo[7:6]} == 4'h0) ? per : per * d / 2);
      gap(1, n);
      gap(1, n);
      check(n, per * d * (ov ? 16 : 1));
    end
    $display("divisor test done");
    // Master mode needs the oscillator at 10 MHz or less
    prog_gen(8'd50);
    per = 10;
    @(posedge clock);
    master <= 2'b11;
    for (q = 0; q < 2; q++) begin
      ch = q;
      r = rnd();
      @(posedge clock);
      cfg4[ch] <= {q[0], 7'h00};
      cmd_wr[ch] <= 1'b1;
      cmd_reg[ch] <= r[7:0];
      @(posedge clock);
      cmd_reg[ch] <= ~r[7:0];
      @(negedge clock);
      check(busy[ch], 1'b1);
      check(cmd_code[ch], r[7:0]);
      @(posedge clock);
      cmd_wr[ch] <= 1'b0;
      @(negedge clock);
      check(lost[ch], 1'b1);
      check(cmd_code[ch], r[7:0]);
      wait_exec(n);
      check(n > 25, q[0]);
      gap(2, n);
      check(n, per * (q[0] ? 4 : 1));
    end
    ch = 0;
    @(posedge clock);
    master[0] <= 1'b0;
    tx_ext[0] <= 1'b1;
    cmd_wr[0] <= 1'b1;
    @(posedge clock);
    cmd_wr[0] <= 1'b0;
    repeat (40) @(negedge clock);
    check(busy[0], 1'b1);
    @(posedge clock);
    tx_pin[0] <= 1'b1;
    repeat (3) @(posedge clock);
    tx_pin[0] <= 1'b0;
    repeat (3) @(posedge clock);
    tx_pin[0] <= 1'b1;
    @(posedge clock);
    tx_pin[0] <= 1'b0;
    wait_exec(n);
    check(n < 12, 1'b1);
    @(posedge clock);
    master <= 2'b00;
    tx_ext[0] <= 1'b0;
    $display("command test done");
    both();
    prog_gen(8'd30);
    per = 6;
    both();
    results();
  end
endmodule
